// File: common/pmr_consts.svh
// Constants for the power mode and reset control block
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH

// Clock and machine cycle
`define PMR_CLK_NS 40
`define PMR_STATES 4
`define PMR_PH_LAST 2'h3
`define PMR_MC_RST 2
`define PMR_HOLD_CYC 4'(`PMR_MC_RST * `PMR_STATES)
`define PMR_WD_RDLY 10'h200
`define PMR_POR_DLY_NS 10000
`define PMR_POR_CYC 8'((`PMR_POR_DLY_NS + `PMR_CLK_NS - 1) / `PMR_CLK_NS)

// Register offsets
`define PMR_OFF_PWR 8'h00
`define PMR_OFF_AUX 8'h01
`define PMR_OFF_WDC 8'h02
`define PMR_OFF_IEN 8'h03
`define PMR_OFF_STAT 8'h04

// Field positions
`define PMR_PWR_IDLE 0
`define PMR_PWR_PD 1
`define PMR_AUX_SOFT_RESET_BIT 0
`define PMR_AUX_BOD 1
`define PMR_AUX_LPBO 2
`define PMR_WDC_CLR 0
`define PMR_WDC_WATCHDOG_RESET_ENABLE 1
`define PMR_WDC_WATCHDOG_RESET_FLAG 2
`define PMR_WDC_WDIF 3
`define PMR_WDC_POR 6
`define PMR_WDC_WATCHDOG_ENABLE_BIT 7
`define PMR_IEN_LVL 2
`define PMR_IEN_EWD 4
`define PMR_IEN_EKB 5
`define PMR_IEN_EAD 6
`define PMR_IEN_EA 7

// Reset values
`define PMR_PWR_RST 2'h0
`define PMR_AUX_RST 2'h0
`define PMR_IEN_RST 8'h00
`define PMR_WDC_RST_POR 8'h40
`define PMR_WDC_KEEP_WDT 8'h40
`define PMR_WDC_VAL_WDT 8'h04
`define PMR_WDC_KEEP_EXT 8'h48
`define PMR_WDC_VAL_EXT 8'h00
`define PMR_SYNC_RST 5'h0f
`define PMR_SP_RST 8'h07
`define PMR_PC_RST 16'h0000
`define PMR_PORT_RST 8'hff

`endif

// File: common/pmr_pkg.sv
// Types for the power mode and reset control block
package pmr_pkg;
    typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_PDOWN} pmr_mode_t;
    typedef enum logic [2:0] {CAUSE_NONE, CAUSE_EXT, CAUSE_POR, CAUSE_WDT, CAUSE_SW} pmr_cause_t;
endpackage : pmr_pkg

// File: design/pmr_ctrl.sv
// Power mode and reset sequencing logic
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "pmr_consts.svh"
// Overview of operation
// [R1] A machine cycle is four clocks; cycle counts use machine cycles.
// [R2] Writing idle bit enters idle after the writing instruction completes.
// [R3] Idle stops only the CPU clock; peripherals keep running, state kept.
// [R4] Port pins hold their levels during idle.
// [R5] Enabled interrupt ends idle, clears idle bit, runs handler.
// [R6] Reset ending idle restarts at zero with register reset values.
// [R7] Watchdog runs in idle; enabled time-out interrupt wakes device.
// [R8] Power-down bit stops all clocks; ports drive register values.
// [R9] Low reset pin ends power-down, restarts clock, start at zero.
// [R10] Watchdog reset cannot end power-down.
// [R11] Enabled level-mode external interrupt with global enable wakes power-down.
// [R12] In power-down, brownout-select high and disable low enables RC clock.
// [R13] Keypad, brownout reset, ADC, watchdog interrupt also wake power-down; code takes the watchdog interrupt only while WDC bit 7 is clear.
// [R14] Reset pin sampled at fourth state; two low samples apply reset.
// [R15] Reset holds while pin low and two machine cycles after.
// [R16] External reset sets no source flag.
// [R17] Supply loss resets; recovery gives delay and sets power-on flag.
// [R18] Watchdog time-out sets flag; reset 512 clocks later, held two cycles.
// [R19] Software reset bit in aux control register resets the device.
// [R20] Reset holds program counter at zero; stack pointer reloaded.
// [R21] Reset disables interrupts, timers, watchdog on power-on; ports go high.
// [R22] Watchdog control reset value depends on the reset source.
// [R23] Watchdog reset sets bit 2, power-on clears it; resets clear bit 1.
// [R24] Leaving power-down clears the power-down bit.
module pmr_ctrl
    import pmr_pkg::*;
#(
    parameter int WD_TIMEOUT = 8192
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic instr_done,
    input wire logic reset_pin_n,
    input wire logic [1:0] ext_int_n,
    input wire logic supply_low,
    input wire logic keypad_interrupt,
    input wire logic adc_irq,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic rc_clk_en,
    output logic port_hold,
    output logic port_from_reg,
    output logic sys_reset,
    output logic cpu_wake,
    output logic wd_irq
);

    // ********************************
    // Declarations
    // ********************************
    logic [1:0] ph_q;
    logic [4:0] sync1_q, sync2_q;
    logic rprev_q, ext_q;
    logic [7:0] por_cnt_q;
    logic [3:0] hold_q;
    logic sys_rst_q, sys_rst_d;
    logic [15:0] wd_cnt_q;
    logic [9:0] wd_rdly_q;
    logic wd_arm_q;
    logic [1:0] pwr_q, pwr_d;
    logic [1:0] aux_q;
    logic [7:0] ien_q, wdc_q, wdc_d, rdata_q;
    logic [1:0] eprev_q;
    logic wake_q;
    pmr_mode_t mode_q, mode_d;
    pmr_cause_t cause_q;

    // ********************************
    // Decode
    // ********************************
    wire st4 = ph_q == `PMR_PH_LAST;
    wire pin_rst = sync2_q[0];
    wire [1:0] pin_int = sync2_q[2:1];
    wire sup_low = sync2_q[3];
    wire por_act = sup_low || (por_cnt_q != 8'h00);
    wire wr_ok = reg_wr && !sys_rst_q;
    wire wr_pwr = wr_ok && reg_addr == `PMR_OFF_PWR;
    wire wr_aux = wr_ok && reg_addr == `PMR_OFF_AUX;
    wire wr_wdc = wr_ok && reg_addr == `PMR_OFF_WDC;
    wire wr_ien = wr_ok && reg_addr == `PMR_OFF_IEN;
    wire sw_rst_p = wr_aux && reg_wdata[`PMR_AUX_SOFT_RESET_BIT];
    wire wd_clr = wr_wdc && reg_wdata[`PMR_WDC_CLR];
    wire ea = ien_q[`PMR_IEN_EA];
    wire in_pd = mode_q == MODE_PDOWN;
    wire wd_run = wdc_q[`PMR_WDC_WATCHDOG_ENABLE_BIT] && (!in_pd || rc_clk_en) && !sys_rst_q;
    wire wd_to_p = wd_run && wd_cnt_q == 16'(WD_TIMEOUT - 1);
    wire wd_rst_p = wd_arm_q && !in_pd && wd_rdly_q == `PMR_WD_RDLY - 10'h001; // R10 R18
    wire [1:0] ei_lvl, ei_evt;

    // ********************************
    // External interrupt detect
    // ********************************
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ei
            assign ei_lvl[gi] = ien_q[`PMR_IEN_LVL + gi] && !pin_int[gi];
            assign ei_evt[gi] = ien_q[gi] && (ien_q[`PMR_IEN_LVL + gi] ? !pin_int[gi] : eprev_q[gi] && !pin_int[gi]);
        end
    endgenerate

    wire wd_int = ien_q[`PMR_IEN_EWD] && wdc_q[`PMR_WDC_WDIF];
    wire kb_int = ien_q[`PMR_IEN_EKB] && keypad_interrupt;
    wire ad_int = ien_q[`PMR_IEN_EAD] && adc_irq;
    wire idle_wake = ea && (|ei_evt || wd_int || kb_int || ad_int); // R5 R7
    wire pd_wake = (ea && |(ei_lvl & ien_q[1:0])) || kb_int || ad_int || // R11
        (wd_int && !wdc_q[`PMR_WDC_WATCHDOG_ENABLE_BIT]); // R13

    // ********************************
    // Machine cycle and pin sampling
    // ********************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ph_q <= 2'h0;
            sync1_q <= `PMR_SYNC_RST;
            sync2_q <= `PMR_SYNC_RST;
            eprev_q <= 2'h3;
        end else begin
            ph_q <= ph_q + 2'h1; // R1
            sync1_q <= {1'b0, supply_low, ext_int_n, reset_pin_n};
            sync2_q <= sync1_q;
            eprev_q <= pin_int;
        end
    end

    // ********************************
    // Reset sources
    // ********************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rprev_q <= 1'b1;
            ext_q <= 1'b0;
            por_cnt_q <= `PMR_POR_CYC;
            hold_q <= 4'h0;
            sys_rst_q <= 1'b1;
        end else begin
            if (st4) begin
                rprev_q <= pin_rst;
                ext_q <= !rprev_q && !pin_rst; // R14 R9
            end
            if (sup_low) begin
                por_cnt_q <= `PMR_POR_CYC; // R17
            end else if (por_cnt_q != 8'h00) begin
                por_cnt_q <= por_cnt_q - 8'h01;
            end
            if (ext_q || wd_rst_p || sw_rst_p) begin
                hold_q <= `PMR_HOLD_CYC; // R15 R18 R19
            end else if (hold_q != 4'h0) begin
                hold_q <= hold_q - 4'h1;
            end
            sys_rst_q <= sys_rst_d;
        end
    end

    assign sys_rst_d = por_act || ext_q || hold_q != 4'h0;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cause_q <= CAUSE_POR;
        end else if (por_act) begin
            cause_q <= CAUSE_POR;
        end else if (wd_rst_p && cause_q != CAUSE_POR) begin
            cause_q <= CAUSE_WDT;
        end else if (sw_rst_p && cause_q == CAUSE_NONE) begin
            cause_q <= CAUSE_SW;
        end else if (ext_q && cause_q == CAUSE_NONE) begin
            cause_q <= CAUSE_EXT;
        end else if (!sys_rst_d && !sys_rst_q) begin
            cause_q <= CAUSE_NONE;
        end
    end

    // ********************************
    // Watchdog
    // ********************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wd_cnt_q <= 16'h0000;
            wd_arm_q <= 1'b0;
            wd_rdly_q <= 10'h000;
        end else begin
            if (wd_clr || wd_to_p || sys_rst_q) begin
                wd_cnt_q <= 16'h0000;
            end else if (wd_run) begin
                wd_cnt_q <= wd_cnt_q + 16'h0001; // R3 R7
            end
            if (wd_clr || sys_rst_q || wd_rst_p) begin
                wd_arm_q <= 1'b0;
            end else if (wd_to_p && wdc_q[`PMR_WDC_WATCHDOG_RESET_ENABLE] && !wd_arm_q) begin
                wd_arm_q <= 1'b1; // R18
                wd_rdly_q <= 10'h000;
            end else if (wd_arm_q && !in_pd) begin
                wd_rdly_q <= wd_rdly_q + 10'h001;
            end
        end
    end

    // ********************************
    // Registers
    // ********************************
    always_comb begin
        wdc_d = wdc_q;
        if (sys_rst_q) begin
            case (cause_q)
                CAUSE_POR: wdc_d = `PMR_WDC_RST_POR; // R17 R21 R22 R23
                CAUSE_WDT: wdc_d = (wdc_q & `PMR_WDC_KEEP_WDT) | `PMR_WDC_VAL_WDT; // R22 R23
                default: wdc_d = (wdc_q & `PMR_WDC_KEEP_EXT) | `PMR_WDC_VAL_EXT; // R16 R22
            endcase
        end else begin
            if (wr_wdc) begin
                wdc_d = {reg_wdata[7:1], 1'b0};
            end
            if (wd_to_p) begin
                wdc_d[`PMR_WDC_WDIF] = 1'b1; // R18
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wdc_q <= `PMR_WDC_RST_POR;
            aux_q <= `PMR_AUX_RST;
            ien_q <= `PMR_IEN_RST;
        end else begin
            wdc_q <= wdc_d;
            if (sys_rst_q) begin
                aux_q <= `PMR_AUX_RST;
                ien_q <= `PMR_IEN_RST; // R6 R21
            end else begin
                if (wr_aux) begin
                    aux_q <= reg_wdata[`PMR_AUX_LPBO:`PMR_AUX_BOD];
                end
                if (wr_ien) begin
                    ien_q <= reg_wdata;
                end
            end
        end
    end

    // ********************************
    // Mode control
    // ********************************
    always_comb begin
        mode_d = mode_q;
        pwr_d = wr_pwr ? reg_wdata[1:0] : pwr_q;
        case (mode_q)
            MODE_RUN: begin
                if (instr_done && pwr_q[`PMR_PWR_PD]) begin
                    mode_d = MODE_PDOWN; // R8
                end else if (instr_done && pwr_q[`PMR_PWR_IDLE]) begin
                    mode_d = MODE_IDLE; // R2
                end
            end
            MODE_IDLE: begin
                if (idle_wake) begin
                    mode_d = MODE_RUN;
                    pwr_d[`PMR_PWR_IDLE] = 1'b0; // R5
                end
            end
            MODE_PDOWN: begin
                if (pd_wake) begin
                    mode_d = MODE_RUN;
                    pwr_d[`PMR_PWR_PD] = 1'b0; // R24
                end
            end
            default: mode_d = MODE_RUN;
        endcase
        if (sys_rst_q) begin
            mode_d = MODE_RUN; // R6 R9
            pwr_d = `PMR_PWR_RST; // R24
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_q <= MODE_RUN;
            pwr_q <= `PMR_PWR_RST;
            wake_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            pwr_q <= pwr_d;
            wake_q <= !sys_rst_q && mode_q != MODE_RUN && mode_d == MODE_RUN;
        end
    end

    // ********************************
    // Read port and outputs
    // ********************************
    wire [7:0] stat = {2'h0, sys_rst_q, cause_q, mode_q};
    wire [7:0] rd_mux = (reg_addr == `PMR_OFF_PWR) ? {6'h00, pwr_q} :
        (reg_addr == `PMR_OFF_AUX) ? {5'h00, aux_q, 1'b0} :
        (reg_addr == `PMR_OFF_WDC) ? wdc_q :
        (reg_addr == `PMR_OFF_IEN) ? ien_q :
        (reg_addr == `PMR_OFF_STAT) ? stat : 8'h00;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end
    end

    assign reg_rdata = rdata_q;
    assign cpu_clk_en = mode_q == MODE_RUN; // R3
    assign periph_clk_en = !in_pd; // R8 R10
    assign rc_clk_en = in_pd && aux_q[1] && !aux_q[0]; // R12
    assign port_hold = mode_q == MODE_IDLE; // R4
    assign port_from_reg = in_pd; // R8
    assign sys_reset = sys_rst_q; // R20 R21
    assign cpu_wake = wake_q;
    assign wd_irq = wd_int;

    // ********************************
    // Assertions
    // ********************************
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_phase_wrap: assert property (st4 |=> ph_q == 2'h0 ##3 st4) else $error("phase bad"); // R1
    a_idle_entry: assert property (mode_q == MODE_RUN && instr_done && pwr_q == 2'h1 && !sys_rst_q // R2
        |=> mode_q == MODE_IDLE && !cpu_clk_en && periph_clk_en) else $error("idle entry");
    a_idle_wake: assert property (mode_q == MODE_IDLE && idle_wake && !sys_rst_q // R5
        |=> mode_q == MODE_RUN && !pwr_q[0] && cpu_wake) else $error("idle wake");
    a_pd_no_wdrst: assert property (in_pd |-> !wd_rst_p) else $error("wd reset in pd"); // R10
    a_pd_rc_clock: assert property (in_pd && aux_q == 2'h2 |-> rc_clk_en && port_from_reg) else $error("rc"); // R12
    a_ext_detect: assert property (st4 && !rprev_q && !pin_rst |=> ##1 sys_rst_q) else $error("ext rst"); // R14
    a_ext_stretch: assert property ($fell(ext_q) |-> sys_rst_q [*8]) else $error("stretch"); // R15
    a_wd_hold: assert property (wd_rst_p |=> ##1 sys_rst_q [*8]) else $error("wd hold"); // R18
    a_wd_flag: assert property (wd_rst_p && !por_act |-> ##[2:12] wdc_q[2]) else $error("watchdog_reset_flag"); // R23
    a_rst_watchdog_reset_enable: assert property ($fell(sys_rst_q) |-> !wdc_q[1] && ien_q == 8'h00) else $error("watchdog_reset_enable"); // R21 R23
    a_pd_exit: assert property (in_pd ##1 mode_q == MODE_RUN |-> !pwr_q[1]) else $error("pd bit"); // R24
    a_pd_clocks: assert property (in_pd // R8
        |-> !cpu_clk_en && !periph_clk_en && port_from_reg && !port_hold) else $error("pd clocks");
    a_idle_ports: assert property (mode_q == MODE_IDLE // R4
        |-> port_hold && periph_clk_en && !cpu_clk_en) else $error("idle ports");
    a_pd_keypad: assert property (in_pd && kb_int && !sys_rst_q // R13
        |=> mode_q == MODE_RUN && cpu_wake) else $error("keypad wake");
    a_rc_off: assert property (!in_pd // R12
        |-> !rc_clk_en) else $error("rc outside pd");
    a_pd_wd_stop: assert property (in_pd && !rc_clk_en // R10
        |-> !wd_run) else $error("wd runs in pd");

    // ********************************
    // Assertions on reset sources
    // ********************************
    a_sw_reset: assert property (sw_rst_p // R19
        |=> ##1 sys_rst_q [*8]) else $error("soft reset hold");
    a_por_enter: assert property (sup_low // R17
        |=> sys_rst_q) else $error("supply reset");
    a_por_pattern: assert property ($fell(sys_rst_q) && cause_q == CAUSE_POR // R17 R21 R22
        |-> wdc_q == `PMR_WDC_RST_POR) else $error("por pattern");
    a_ext_pattern: assert property ($fell(sys_rst_q) && cause_q == CAUSE_EXT // R16 R22
        |-> !wdc_q[`PMR_WDC_WATCHDOG_RESET_FLAG] && !wdc_q[`PMR_WDC_WATCHDOG_RESET_ENABLE] && !wdc_q[`PMR_WDC_WATCHDOG_ENABLE_BIT]) else $error("ext pattern");
    a_ext_single: assert property (st4 && rprev_q && !pin_rst // R14
        |=> !ext_q) else $error("single low sample");
    a_wd_cancel: assert property (wd_clr // R18
        |=> !wd_arm_q) else $error("wd cancel");
    a_wd_flag_set: assert property (wd_to_p // R7
        |=> wdc_q[`PMR_WDC_WDIF]) else $error("wd flag");
    a_rst_mode: assert property (sys_rst_q // R6
        |=> mode_q == MODE_RUN && pwr_q == 2'h0) else $error("reset mode");

    c_idle_cycle: cover property (mode_q == MODE_IDLE ##1 mode_q == MODE_RUN);
    c_sw_reset: cover property (sw_rst_p);
    c_pd_wake: cover property (in_pd ##1 mode_q == MODE_RUN && cpu_wake);
    c_wd_reset: cover property (wd_rst_p);
    c_ext_reset: cover property ($rose(ext_q));

endmodule : pmr_ctrl

// File: test/pmr_pin_model.sv
// External reset pin and interrupt pin model
`timescale 1ns/1ps
module pmr_pin_model #(
    parameter int MIN_LOW = 16
) (
    input wire logic mclk,
    input wire logic rst_req,
    input wire logic [1:0] int_req,
    output logic reset_pin_n,
    output logic [1:0] ext_int_n
);
    logic rst_pin_q = 1'b1;
    logic [1:0] int_pin_q = 2'h3;
    int low_cnt = 0;
    assign reset_pin_n = rst_pin_q;
    assign ext_int_n = int_pin_q;
    // ****************************************
    // Pin drive, pulled high when released
    // ****************************************
    always @(posedge mclk) begin
        if (rst_req || (low_cnt != 0 && low_cnt < MIN_LOW)) begin
            rst_pin_q <= 1'b0;
            low_cnt <= low_cnt + 1;
        end else begin
            rst_pin_q <= 1'b1;
            low_cnt <= 0;
        end
        int_pin_q <= ~int_req;
    end
endmodule : pmr_pin_model

// File: test/power_mode_and_reset_control_tb_top.sv
// Testbench for the power mode and reset control block
`timescale 1ns/1ps
`include "pmr_consts.svh"
module power_mode_and_reset_control_tb_top;
    import pmr_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, instr_done = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic supply_low = 1'b0, keypad_interrupt = 1'b0, adc_irq = 1'b0, rst_req = 1'b0;
    logic [1:0] int_req = 2'h0, ext_int_n;
    logic reset_pin_n, cpu_clk_en, periph_clk_en, rc_clk_en, port_hold, port_from_reg, sys_reset, cpu_wake, wd_irq;
    int miscompares = 0, n_checks = 0, cyc = 0, n;
    always #20 mclk = ~mclk;
    pmr_ctrl #(.WD_TIMEOUT(64)) u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_done(instr_done),
        .reset_pin_n(reset_pin_n), .ext_int_n(ext_int_n), .supply_low(supply_low),
        .keypad_interrupt(keypad_interrupt), .adc_irq(adc_irq), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .rc_clk_en(rc_clk_en), .port_hold(port_hold),
        .port_from_reg(port_from_reg), .sys_reset(sys_reset), .cpu_wake(cpu_wake), .wd_irq(wd_irq));
    pmr_pin_model u_pins (.mclk(mclk), .rst_req(rst_req), .int_req(int_req), .reset_pin_n(reset_pin_n),
        .ext_int_n(ext_int_n));
    // ****************************************
    // Shared tasks
    // ****************************************
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc >= 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk8
    task chk1(input string nm, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk1
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk8(nm, exp, reg_rdata);
    endtask : rd_chk
    task wait_sr(input logic lvl, input int lim);
        for (int i = 0; i < lim && sys_reset !== lvl; i++) begin
            @(posedge mclk);
            #1;
        end
        chk1("sys_reset", lvl, sys_reset);
    endtask : wait_sr
    task wait_wake(input int lim);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(posedge mclk);
            #1;
            seen = (cpu_wake === 1'b1);
        end
        chk1("cpu_wake", 1'b1, seen);
    endtask : wait_wake
    task step_instr;
        @(posedge mclk);
        instr_done <= 1'b1;
        @(posedge mclk);
        instr_done <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : step_instr
    // ****************************************
    // Scenarios
    // ****************************************
    task t_power_on;
        rd_chk("status_in_por", `PMR_OFF_STAT, 8'h28);
        wait_sr(1'b0, 400);
        rd_chk("wdc_por", `PMR_OFF_WDC, `PMR_WDC_RST_POR);
        rd_chk("status_por", `PMR_OFF_STAT, 8'h00);
        rd_chk("ien_rst", `PMR_OFF_IEN, `PMR_IEN_RST);
        rd_chk("unmapped", 8'h10, 8'h00);
        wr(`PMR_OFF_WDC, 8'h00);
        rd_chk("wdc_clr", `PMR_OFF_WDC, 8'h00);
        $display("test power_on done");
    endtask : t_power_on
    task t_idle;
        wr(`PMR_OFF_IEN, 8'h81);
        wr(`PMR_OFF_PWR, 8'h01);
        #1;
        chk1("cpu_clk_before", 1'b1, cpu_clk_en);
        step_instr();
        chk1("cpu_clk_idle", 1'b0, cpu_clk_en);
        chk1("periph_idle", 1'b1, periph_clk_en);
        chk1("port_hold", 1'b1, port_hold);
        int_req <= 2'h1;
        wait_wake(30);
        int_req <= 2'h0;
        rd_chk("pwr_after_idle", `PMR_OFF_PWR, 8'h00);
        chk1("cpu_clk_run", 1'b1, cpu_clk_en);
        $display("test idle done");
    endtask : t_idle
    task t_pdown;
        wr(`PMR_OFF_IEN, 8'h85);
        wr(`PMR_OFF_AUX, 8'h04);
        wr(`PMR_OFF_PWR, 8'h02);
        step_instr();
        chk1("periph_pd", 1'b0, periph_clk_en);
        chk1("port_from_reg", 1'b1, port_from_reg);
        chk1("rc_clk_en", 1'b1, rc_clk_en);
        chk1("cpu_clk_pd", 1'b0, cpu_clk_en);
        int_req <= 2'h1;
        wait_wake(30);
        int_req <= 2'h0;
        rd_chk("pwr_after_pd", `PMR_OFF_PWR, 8'h00);
        chk1("periph_back", 1'b1, periph_clk_en);
        wr(`PMR_OFF_IEN, 8'h20);
        wr(`PMR_OFF_PWR, 8'h02);
        step_instr();
        chk1("port_from_reg_kb", 1'b1, port_from_reg);
        @(posedge mclk);
        keypad_interrupt <= 1'b1;
        wait_wake(10);
        @(posedge mclk);
        keypad_interrupt <= 1'b0;
        wr(`PMR_OFF_PWR, 8'h02);
        step_instr();
        rst_req <= 1'b1;
        wait_sr(1'b1, 40);
        rd_chk("status_in_ext", `PMR_OFF_STAT, 8'h24);
        rst_req <= 1'b0;
        wait_sr(1'b0, 60);
        rd_chk("status_ext", `PMR_OFF_STAT, 8'h00);
        rd_chk("wdc_ext", `PMR_OFF_WDC, `PMR_WDC_VAL_EXT);
        rd_chk("pwr_ext", `PMR_OFF_PWR, 8'h00);
        $display("test power_down done");
    endtask : t_pdown
    task t_watchdog;
        wr(`PMR_OFF_IEN, 8'h10);
        wr(`PMR_OFF_WDC, 8'h82);
        repeat (70) @(posedge mclk);
        #1;
        chk1("wd_irq", 1'b1, wd_irq);
        wait_sr(1'b1, 900);
        rd_chk("status_in_wdt", `PMR_OFF_STAT, 8'h2c);
        n = 2;
        while (sys_reset === 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk1("wdt_hold_len", 1'b1, n >= 8);
        rd_chk("wdc_wdt", `PMR_OFF_WDC, `PMR_WDC_VAL_WDT);
        rd_chk("status_wdt", `PMR_OFF_STAT, 8'h00);
        $display("test watchdog done");
    endtask : t_watchdog
    task t_soft;
        wr(`PMR_OFF_IEN, 8'hff);
        wr(`PMR_OFF_AUX, 8'h01);
        wait_sr(1'b1, 10);
        rd_chk("status_in_sw", `PMR_OFF_STAT, 8'h30);
        wait_sr(1'b0, 30);
        rd_chk("ien_sw", `PMR_OFF_IEN, 8'h00);
        rd_chk("aux_sw", `PMR_OFF_AUX, 8'h00);
        rd_chk("status_sw", `PMR_OFF_STAT, 8'h00);
        rd_chk("wdc_sw", `PMR_OFF_WDC, 8'h00);
        $display("test soft_reset done");
    endtask : t_soft
    task t_supply;
        @(posedge mclk);
        supply_low <= 1'b1;
        repeat (6) @(posedge mclk);
        supply_low <= 1'b0;
        wait_sr(1'b1, 5);
        rd_chk("status_in_supply", `PMR_OFF_STAT, 8'h28);
        wait_sr(1'b0, 400);
        rd_chk("wdc_supply", `PMR_OFF_WDC, `PMR_WDC_RST_POR);
        rd_chk("status_supply", `PMR_OFF_STAT, 8'h00);
        $display("test supply done");
    endtask : t_supply
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        t_power_on();
        t_idle();
        t_pdown();
        t_watchdog();
        t_soft();
        t_supply();
        report_and_stop();
    end
endmodule : power_mode_and_reset_control_tb_top
